/* compact_timer_unit.sv */
// compact ten-bit timer with compare output and pwm, ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
module compact_timer_unit (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output var logic [31:0] hrdata,
   output logic hresp,
   input wire logic high_clock,
   input wire logic sub_clock,
   output var logic timer_output_pin,
   output var logic timer_output_inverted_pin,
   output var logic compare_a_match_req,
   output var logic period_match_req,
   output var compact_timer_pkg::ctrl_b_t ctrl_b_view
);
   import compact_timer_pkg::*;

   ctrl_a_t ctrl_a_q;
   ctrl_b_t ctrl_b_q;
   logic [9:0] cnt_q;
   logic [9:0] cmp_q;
   logic [7:0] buf_q;
   logic run_prev_q;
   logic out_level_q;
   logic [1:0] sys_div_q;
   logic [5:0] h_div_q;
   logic wr_pend_q;
   logic rd_pend_q;
   logic [7:0] addr_q;
   logic acc_valid;
   logic [31:0] rd_value;
   logic [1:0] ext_in;
   logic [1:0] ext_edge;
   logic sel_pulse;
   logic tick;
   logic run_rise;
   logic [10:0] cnt_inc;
   logic p_hit;
   logic a_hit;
   logic ovf;
   logic p_evt;
   logic clr_by_a;
   logic cnt_clear;
   logic is_pwm;
   logic [10:0] duty_val;
   logic pwm_on;

   assign hresp = 1'b0;
   assign ctrl_b_view = ctrl_b_q;

   // ahb-lite slave: writes take no wait, reads take one
   assign acc_valid = hsel && htrans[1] && hready;
   assign hreadyout = !rd_pend_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end else if (clk_en) begin
         wr_pend_q <= acc_valid && hwrite;
         rd_pend_q <= acc_valid && !hwrite;
         if (acc_valid) begin
            addr_q <= {haddr[7:2], 2'b00};
         end
      end
   end

   // read mux, low bytes come from the shared buffer
   always_comb begin
      rd_value = 32'h0000_0000;
      case (addr_q)
         OFF_CTRL_A: rd_value = {24'h00_0000, ctrl_a_q};
         OFF_CTRL_B: rd_value = {24'h00_0000, ctrl_b_q};
         OFF_CNT_LO: rd_value = {24'h00_0000, buf_q}; // R22
         OFF_CNT_HI: rd_value = {30'h0000_0000, cnt_q[9:8]}; // R21
         OFF_CMP_LO: rd_value = {24'h00_0000, buf_q}; // R22
         OFF_CMP_HI: rd_value = {30'h0000_0000, cmp_q[9:8]};
         default: rd_value = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (clk_en && rd_pend_q) begin
         hrdata <= rd_value;
      end
   end

   // byte buffer: compare low write fills, high read latches low byte
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         buf_q <= 8'h00;
      end else if (clk_en) begin
         if (wr_pend_q && addr_q == OFF_CMP_LO) begin
            buf_q <= hwdata[7:0]; // R22
         end else if (rd_pend_q && addr_q == OFF_CNT_HI) begin
            buf_q <= cnt_q[7:0]; // R22
         end else if (rd_pend_q && addr_q == OFF_CMP_HI) begin
            buf_q <= cmp_q[7:0]; // R22
         end
      end
   end

   // control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_a_q <= CTRL_A_RESET;
         ctrl_b_q <= CTRL_B_RESET;
      end else if (clk_en && wr_pend_q) begin
         if (addr_q == OFF_CTRL_A) begin
            ctrl_a_q <= hwdata[7:0];
         end
         if (addr_q == OFF_CTRL_B) begin
            ctrl_b_q <= hwdata[7:0];
         end
      end
   end

   // compare value, high write commits the buffer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_q <= CMP_RESET;
      end else if (clk_en && wr_pend_q && addr_q == OFF_CMP_HI) begin
         cmp_q <= {hwdata[1:0], buf_q}; // R22
      end
   end

   // clock pins, two flip-flops then edge detect
   assign ext_in = {sub_clock, high_clock};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_ext
         logic s1_q;
         logic s2_q;
         logic s3_q;
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
            end else if (clk_en) begin
               s1_q <= ext_in[gi];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end
         assign ext_edge[gi] = s2_q && !s3_q;
      end
   endgenerate

   // dividers for system and high clocks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sys_div_q <= 2'h0;
         h_div_q <= 6'h00;
      end else if (clk_en) begin
         sys_div_q <= sys_div_q + 2'h1;
         if (ext_edge[0]) begin
            h_div_q <= h_div_q + 6'h01;
         end
      end
   end

   // counter clock select
   always_comb begin
      case (ctrl_a_q.clk_sel)
         3'b000: sel_pulse = (sys_div_q == SYS_DIV_LAST); // R6
         3'b001: sel_pulse = 1'b1; // R6
         3'b010: sel_pulse = ext_edge[0] && ((h_div_q & H_DIV16_MASK) == H_DIV16_MASK); // R6
         3'b011: sel_pulse = ext_edge[0] && (h_div_q == H_DIV64_LAST); // R6
         3'b100: sel_pulse = ext_edge[1]; // R6
         3'b101: sel_pulse = ext_edge[1]; // R6
         default: sel_pulse = 1'b0;
      endcase
   end

   assign tick = sel_pulse && ctrl_a_q.run && !ctrl_a_q.pause; // R5
   assign run_rise = ctrl_a_q.run && !run_prev_q; // R7
   assign is_pwm = (ctrl_b_q.mode == MODE_PWM);

   // comparators
   assign cnt_inc = {1'b0, cnt_q} + 11'h001; // R1
   assign p_hit = tick && (ctrl_a_q.period != 3'b000)
      && (cnt_inc[9:0] == {ctrl_a_q.period, 7'h00}); // R2 R9 R10
   assign a_hit = tick && (cmp_q != 10'h000) && (cnt_inc[9:0] == cmp_q); // R3
   assign ovf = tick && cnt_inc[10]; // R25
   assign p_evt = p_hit || ((ctrl_a_q.period == 3'b000) && ovf); // R10
   assign clr_by_a = is_pwm ? ctrl_b_q.swap : ctrl_b_q.clear_sel; // R19 R20
   assign cnt_clear = clr_by_a ? a_hit : p_evt; // R4 R20

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_prev_q <= 1'b0;
      end else if (clk_en) begin
         run_prev_q <= ctrl_a_q.run;
      end
   end

   // counter, cleared only by run rise or hardware events
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= CNT_RESET;
      end else if (clk_en) begin
         if (run_rise) begin
            cnt_q <= CNT_RESET; // R4 R7
         end else if (tick) begin
            cnt_q <= cnt_clear ? CNT_RESET : cnt_inc[9:0]; // R1 R4 R25
         end
      end
   end

   // match requests
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_a_match_req <= 1'b0;
         period_match_req <= 1'b0;
      end else if (clk_en) begin
         compare_a_match_req <= a_hit; // R24
         period_match_req <= p_evt && (is_pwm || !ctrl_b_q.clear_sel); // R24 R20
      end
   end

   // pwm duty threshold
   always_comb begin
      if (ctrl_b_q.swap) begin
         if (ctrl_a_q.period == 3'b000) begin
            duty_val = FULL_PERIOD; // R19 R9
         end else begin
            duty_val = {1'b0, ctrl_a_q.period, 7'h00}; // R19 R9
         end
      end else begin
         duty_val = {1'b0, cmp_q}; // R19
      end
   end
   assign pwm_on = ({1'b0, cnt_q} < duty_val);

   // output level before polarity
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_level_q <= 1'b0;
      end else if (clk_en) begin
         if (run_rise && (ctrl_b_q.mode == MODE_COMPARE || is_pwm)) begin
            out_level_q <= ctrl_b_q.out_ctl; // R8 R17
         end else if (ctrl_b_q.mode == MODE_COMPARE) begin
            if (a_hit) begin
               case (ctrl_b_q.out_fn)
                  2'b01: out_level_q <= 1'b0; // R13 R14
                  2'b10: out_level_q <= 1'b1; // R13 R14
                  2'b11: out_level_q <= !out_level_q; // R13
                  default: out_level_q <= out_level_q; // R13
               endcase
            end
         end else if (is_pwm) begin
            case (ctrl_b_q.out_fn)
               2'b00: out_level_q <= !ctrl_b_q.out_ctl; // R15
               2'b01: out_level_q <= ctrl_b_q.out_ctl; // R15 R17
               2'b10: out_level_q <= pwm_on ? ctrl_b_q.out_ctl : !ctrl_b_q.out_ctl; // R15
               default: out_level_q <= !ctrl_b_q.out_ctl;
            endcase
         end
      end
   end

   // pins, inverse pin always the complement
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_output_pin <= 1'b0;
         timer_output_inverted_pin <= 1'b1;
      end else if (clk_en) begin
         if (ctrl_b_q.mode == MODE_TIMER) begin
            timer_output_pin <= 1'b0; // R11
            timer_output_inverted_pin <= 1'b1; // R23
         end else begin
            timer_output_pin <= out_level_q ^ ctrl_b_q.polarity; // R18
            timer_output_inverted_pin <= !(out_level_q ^ ctrl_b_q.polarity); // R23
         end
      end
   end

   // checks
   a_count_step: assert property (@(posedge hclk) disable iff (!hresetn) // R1
      (clk_en && tick && !cnt_clear && !run_rise) |=> cnt_q == $past(cnt_q) + 10'h001)
      else $error("counter did not step by one");

   a_run_rise_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R7
      (clk_en && run_rise) |=> cnt_q == 10'h000)
      else $error("run rise did not zero counter");

   a_pause_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R5
      (ctrl_a_q.pause && !run_rise) |=> $stable(cnt_q))
      else $error("counter moved while paused");

   a_off_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R7
      (!ctrl_a_q.run) |=> $stable(cnt_q))
      else $error("counter moved while off");

   a_period_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R2
      (clk_en && p_hit && !clr_by_a && !run_rise) |=> cnt_q == 10'h000)
      else $error("period match did not clear counter");

   a_zero_period: assert property (@(posedge hclk) disable iff (!hresetn) // R10
      (ctrl_a_q.period == 3'b000) |-> !p_hit)
      else $error("period match with zero period");

   a_init_level: assert property (@(posedge hclk) disable iff (!hresetn) // R8
      (clk_en && run_rise && ctrl_b_q.mode == MODE_COMPARE)
      |=> out_level_q == $past(ctrl_b_q.out_ctl))
      else $error("initial level not loaded");

   a_match_high: assert property (@(posedge hclk) disable iff (!hresetn) // R13
      (clk_en && a_hit && !run_rise && ctrl_b_q.mode == MODE_COMPARE
      && ctrl_b_q.out_fn == 2'b10) |=> out_level_q)
      else $error("compare match did not drive high");

   a_pins_inverse: assert property (@(posedge hclk) disable iff (!hresetn) // R23
      timer_output_inverted_pin == !timer_output_pin)
      else $error("second pin not inverse");

   a_period_req: assert property (@(posedge hclk) disable iff (!hresetn) // R24
      (clk_en && p_hit && !is_pwm && ctrl_b_q.clear_sel) |=> !period_match_req)
      else $error("period request with compare clear");

   a_buffer_latch: assert property (@(posedge hclk) disable iff (!hresetn) // R22
      (clk_en && rd_pend_q && addr_q == OFF_CNT_HI)
      |=> {2'b00, buf_q} == ($past(cnt_q) & 10'h0ff))
      else $error("count low byte not latched");

   a_compare_commit: assert property (@(posedge hclk) disable iff (!hresetn) // R22
      (clk_en && wr_pend_q && addr_q == OFF_CMP_HI) |=> cmp_q[7:0] == $past(buf_q))
      else $error("compare low byte not committed");

   a_timer_pin_low: assert property (@(posedge hclk) disable iff (!hresetn) // R11 R23
      (clk_en && ctrl_b_q.mode == MODE_TIMER) |=> !timer_output_pin && timer_output_inverted_pin)
      else $error("pin not low in timer mode");

   a_pwm_active: assert property (@(posedge hclk) disable iff (!hresetn) // R15
      (clk_en && is_pwm && ctrl_b_q.out_fn == 2'b01) |=> out_level_q == $past(ctrl_b_q.out_ctl))
      else $error("pwm active level not forced");

   a_compare_req: assert property (@(posedge hclk) disable iff (!hresetn) // R24
      (clk_en && a_hit) |=> compare_a_match_req)
      else $error("compare match gave no request");

   a_undefined_clock: assert property (@(posedge hclk) disable iff (!hresetn) // R6
      (ctrl_a_q.clk_sel[2:1] == 2'b11) |-> !tick)
      else $error("undefined clock select counted");

   a_overflow_wrap: assert property (@(posedge hclk) disable iff (!hresetn) // R10 R25
      (clk_en && ovf && !run_rise) |=> cnt_q == 10'h000)
      else $error("counter did not wrap on overflow");

   a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn) // R21
      (clk_en && acc_valid && !hwrite) |=> !hreadyout)
      else $error("read took no wait state");

   c_pwm_run: cover property (@(posedge hclk) disable iff (!hresetn)
      is_pwm && ctrl_a_q.run && ctrl_b_q.out_fn == 2'b10 && pwm_on ##1 !pwm_on);
   c_toggle: cover property (@(posedge hclk) disable iff (!hresetn)
      clk_en && a_hit && ctrl_b_q.mode == MODE_COMPARE && ctrl_b_q.out_fn == 2'b11);
   c_period_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
      clk_en && p_hit ##1 cnt_q == 10'h000);
   c_pause_run: cover property (@(posedge hclk) disable iff (!hresetn)
      ctrl_a_q.run && ctrl_a_q.pause ##1 !ctrl_a_q.pause);
   c_swap_pwm: cover property (@(posedge hclk) disable iff (!hresetn)
      clk_en && is_pwm && ctrl_b_q.swap && a_hit);
endmodule
`default_nettype wire

/* compact_timer_pkg.sv */
// constants and types for the compact timer and pwm unit
//
// Function
// R1 - ten-bit counter counts up on selected clock
// R2 - period value compares counter bits nine to seven
// R3 - compare value matches all ten counter bits
// R4 - counter cleared by run edge, overflow, match
// R5 - pause bit freezes counter, clearing resumes
// R6 - clock select picks divided system, high, sub
// R7 - run off holds count, run rise zeroes
// R8 - run rise loads initial pin level
// R9 - period code counts 128 steps, zero is 1024
// R10 - zero period field lets counter overflow
// R11 - mode field selects compare, pwm, timer
// R12 - software stops timer before changing mode
// R13 - compare match drives pin per function field
// R14 - same level as initial gives no change
// R15 - pwm function field forces or drives waveform
// R16 - software changes pwm function only when off
// R17 - control bit sets initial or active level
// R18 - polarity bit inverts pin outside timer mode
// R19 - swap bit exchanges period and duty comparators
// R20 - clear select picks compare or period clear
// R21 - counter readable as low and high bytes
// R22 - low bytes pass through shared byte buffer
// R23 - second pin always inverse of first pin
// R24 - separate compare and period match requests
// R25 - counter steps by one, wraps at maximum
package compact_timer_pkg;
   localparam logic [7:0] OFF_CTRL_A = 8'h00;
   localparam logic [7:0] OFF_CTRL_B = 8'h04;
   localparam logic [7:0] OFF_CNT_LO = 8'h08;
   localparam logic [7:0] OFF_CNT_HI = 8'h0c;
   localparam logic [7:0] OFF_CMP_LO = 8'h10;
   localparam logic [7:0] OFF_CMP_HI = 8'h14;
   localparam logic [7:0] CTRL_A_RESET = 8'h00;
   localparam logic [7:0] CTRL_B_RESET = 8'h00;
   localparam logic [9:0] CNT_RESET = 10'h000;
   localparam logic [9:0] CMP_RESET = 10'h000;
   localparam int unsigned PERIOD_LSB = 7;
   localparam logic [1:0] SYS_DIV_LAST = 2'h3;
   localparam logic [5:0] H_DIV16_MASK = 6'h0f;
   localparam logic [5:0] H_DIV64_LAST = 6'h3f;
   localparam logic [10:0] FULL_PERIOD = 11'h400;
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_UNDEF = 2'b01,
      MODE_PWM = 2'b10,
      MODE_TIMER = 2'b11
   } mode_t;
   typedef struct packed {
      logic pause;
      logic [2:0] clk_sel;
      logic run;
      logic [2:0] period;
   } ctrl_a_t;
   typedef struct packed {
      mode_t mode;
      logic [1:0] out_fn;
      logic out_ctl;
      logic polarity;
      logic swap;
      logic clear_sel;
   } ctrl_b_t;
endpackage

/* compact_timer_unit_tb.sv */
// self-checking testbench for the compact timer and pwm unit
`timescale 1ns/1ps
`default_nettype none
module compact_timer_unit_tb;
   import compact_timer_pkg::*;
   logic hclk, hresetn, clk_en, hsel, hwrite, hready;
   logic high_clock = 1'b0;
   logic sub_clock = 1'b0;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, pin, pin_n, cmp_req, per_req;
   ctrl_b_t ctrl_b_view;
   logic [9:0] cnt_a, cnt_b;
   int miscompares, num_checks, n, hi, e;
   logic [9:0] cm_case [6] = '{10'h0c5, 10'h085, 10'h044, 10'h066, 10'h004, 10'h0d6};
   logic [7:0] pw_ctl [6] = '{8'ha8, 8'ha0, 8'ha4, 8'h98, 8'h88, 8'haa};
   int pw_win [6] = '{128, 128, 128, 128, 128, 32};
   int pw_hi [6] = '{32, 96, 32, 128, 0, 32};
   assign hready = hreadyout;
   compact_timer_unit compact_timer_unit_i (
      .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .high_clock(high_clock),
      .sub_clock(sub_clock), .timer_output_pin(pin), .timer_output_inverted_pin(pin_n),
      .compare_a_match_req(cmp_req), .period_match_req(per_req), .ctrl_b_view(ctrl_b_view)
   );
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // both slow clocks give one rising edge every two system clocks
   always @(posedge hclk) begin
      high_clock <= ~high_clock;
      sub_clock <= high_clock;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hready !== 1'b1 && k < 20);
      if (hready !== 1'b1) miscompares++;
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
      check("response", 32'h0000_0000, {31'h0000_0000, hresp});
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(what, exp, rd);
   endtask
   task automatic read_count(output logic [9:0] v);
      bus(1'b0, OFF_CNT_HI, 32'h0000_0000);
      v[9:8] = rd[1:0];
      check("count high unused", 32'h0000_0000, {2'b00, rd[31:2]});
      bus(1'b0, OFF_CNT_LO, 32'h0000_0000);
      v[7:0] = rd[7:0];
   endtask
   task automatic wait_req(input logic per, output int cnt);
      cnt = 0;
      do begin
         @(posedge hclk);
         cnt++;
      end while ((per ? per_req : cmp_req) !== 1'b1 && cnt < 3000);
      if ((per ? per_req : cmp_req) !== 1'b1) miscompares++;
   endtask
   task automatic restart(input logic [7:0] b, input logic [7:0] a);
      bus(1'b1, OFF_CTRL_A, 32'h0000_0000);
      bus(1'b1, OFF_CTRL_B, {24'h00_0000, b});
      bus(1'b1, OFF_CTRL_A, {24'h00_0000, a});
   endtask
   initial begin
      repeat (50000) @(posedge hclk);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      clk_en = 1'b1;
      hsize = 3'h2;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 7; i++) rd_chk("reset value", 8'(i * 4), 32'h0000_0000);
      bus(1'b1, OFF_CTRL_B, 32'h0000_005a);
      rd_chk("control b", OFF_CTRL_B, 32'h0000_005a);
      check("control b view", 32'h0000_005a, {24'h00_0000, ctrl_b_view});
      bus(1'b1, 8'h18, 32'h0000_00ff);
      rd_chk("unmapped", 8'h18, 32'h0000_0000);
      bus(1'b1, OFF_CNT_HI, 32'h0000_0003);
      rd_chk("count high write", OFF_CNT_HI, 32'h0000_0000);
      bus(1'b1, OFF_CMP_LO, 32'h0000_00a5);
      rd_chk("compare high before", OFF_CMP_HI, 32'h0000_0000);
      rd_chk("compare low before", OFF_CMP_LO, 32'h0000_0000);
      bus(1'b1, OFF_CMP_LO, 32'h0000_00a5);
      bus(1'b1, OFF_CMP_HI, 32'h0000_0002);
      rd_chk("compare high", OFF_CMP_HI, 32'h0000_0002);
      rd_chk("compare low", OFF_CMP_LO, 32'h0000_00a5);
      // period spacing in system clocks for codes 1, 2 and 0
      for (int p = 0; p < 3; p++) begin
         e = (p == 2) ? 0 : p + 1;
         restart(8'h00, 8'(8'h18 + e));
         wait_req(1'b1, n);
         wait_req(1'b1, n);
         check("period spacing", (e == 0) ? 1024 : e * 128, n);
      end
      // each clock select code over a 512-cycle window, then paused
      for (int c = 0; c < 8; c++) begin
         restart(8'hcc, 8'(c * 16 + 8));
         repeat (512) @(posedge hclk);
         check("timer mode pin", 32'h0000_0001, {31'h0, !pin && pin_n});
         bus(1'b1, OFF_CTRL_A, 32'(c * 16 + 136));
         read_count(cnt_a);
         e = (c == 0) ? 128 : (c == 1) ? 512 : (c == 2) ? 16 : (c == 3) ? 4 : (c < 6) ? 256 : 0;
         check("clock select count", 1, int'(cnt_a) + 4 >= e && int'(cnt_a) <= e + 4);
         repeat (20) @(posedge hclk);
         read_count(cnt_b);
         check("paused count", cnt_a, cnt_b);
      end
      restart(8'hc0, 8'h18);
      repeat (100) @(posedge hclk);
      bus(1'b1, OFF_CTRL_A, 32'h0000_0010);
      read_count(cnt_a);
      repeat (20) @(posedge hclk);
      read_count(cnt_b);
      check("count held when off", cnt_a, cnt_b);
      check("count advanced", 1, cnt_a > 10'h064);
      bus(1'b1, OFF_CTRL_A, 32'h0000_0018);
      bus(1'b1, OFF_CTRL_A, 32'h0000_0098);
      read_count(cnt_a);
      check("count zeroed on run", 1, cnt_a < 10'h008);
      bus(1'b1, OFF_CTRL_A, 32'h0000_0018);
      read_count(cnt_b);
      check("count resumed", 1, cnt_b > cnt_a && cnt_b < cnt_a + 10'h014);
      bus(1'b1, OFF_CMP_LO, 32'h0000_0040);
      bus(1'b1, OFF_CMP_HI, 32'h0000_0000);
      // compare output: control b value, initial pin, pin after one match
      for (int i = 0; i < 6; i++) begin
         restart(cm_case[i][9:2], 8'h18);
         repeat (3) @(posedge hclk);
         check("initial pin", {31'h0, cm_case[i][1]}, {31'h0, pin});
         check("inverted pin", {31'h0, ~cm_case[i][1]}, {31'h0, pin_n});
         wait_req(1'b0, n);
         repeat (3) @(posedge hclk);
         check("pin after match", {31'h0, cm_case[i][0]}, {31'h0, pin});
         check("inverted after match", {31'h0, ~cm_case[i][0]}, {31'h0, pin_n});
         wait_req(1'b0, n);
         wait_req(1'b0, n);
         check("compare spacing", 64, n);
      end
      bus(1'b1, OFF_CMP_LO, 32'h0000_0020);
      bus(1'b1, OFF_CMP_HI, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         restart(pw_ctl[i], 8'h19);
         repeat (300) @(posedge hclk);
         hi = 0;
         for (int k = 0; k < pw_win[i]; k++) begin
            @(posedge hclk);
            if (pin === 1'b1) hi++;
         end
         check("pwm high cycles", pw_hi[i], hi);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
